// [design/safety_channel_config_objects.sv]
// Configuration objects of the single-channel safety connection and channel settings.
// What this block does
// - The safety channel stays disabled after reset and until the safety module is configured in a slot.
// - The checksum is one of eight fixed polynomials numbered one to eight or a free value.
// - The checksum selection or the free value is held in the connection-mode subindex.
// - Address and checksum are written into the safety settings and must match the master's.
// - The index of the safety settings object is a per-product constant.
// - On every enable the full process data set is offered, which the master may narrow.
// - A small test current is periodically driven through each sensor loop.
// - Voltage sampling is suspended for the whole of every test pulse.
// - Software may switch open-wire testing off per channel where supported.
// - Writing the restore key to the restore command returns all backed-up objects to defaults.
// - Input data sit at 0x60n0, output data at 0x70n0 and channel settings at 0x80n0.
`timescale 1ns/100ps
`default_nettype none
module safety_channel_config_objects
	import safety_cfg_pkg::*;
#(
	parameter int CHANNELS = 4,
	parameter logic [15:0] SAFETY_INDEX = safety_cfg_pkg::SAFETY_INDEX_DEFAULT,
	parameter bit WB_OFF_SUPPORTED = 1'b1,
	parameter int PERIOD_US = safety_cfg_pkg::TEST_PERIOD_US,
	parameter int PULSE_US = safety_cfg_pkg::TEST_PULSE_US
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Object dictionary access
	input wire logic od_req,
	input wire logic od_write,
	input wire logic [15:0] od_index,
	input wire logic [7:0] od_subindex,
	input wire logic [31:0] od_wdata,
	output logic od_ack,
	output logic od_abort,
	output logic [31:0] od_rdata,
	// Safety connection
	input wire logic slot_configured,
	output logic safety_enable,
	output logic [15:0] safety_addr,
	output logic [31:0] crc_value,
	output logic [7:0] pd_size,
	// Channels
	input wire logic [CHANNELS*16-1:0] ch_value,
	output logic [CHANNELS*16-1:0] out_value,
	output logic [CHANNELS-1:0] test_current,
	output logic [CHANNELS-1:0] sample_enable
);
	import safety_cfg_pkg::*;

	if (CHANNELS < 1 || CHANNELS > 16) begin : g_check
		$error("safety_channel_config_objects: CHANNELS must be 1 to 16");
	end

	// Matches 0xA0n0 for area A and an existing channel n.
	function automatic logic area_hit(input logic [15:0] idx, input logic [3:0] area);
		return idx[15:12] == area && idx[11:8] == AREA_PAD && idx[3:0] == AREA_PAD
			&& int'(idx[7:4]) < CHANNELS;
	endfunction : area_hit

	// ==========================================================
	// Microsecond tick
	logic [7:0] tick_count, next_tick_count;
	logic tick, next_tick;
	always_comb begin
		next_tick = tick_count == 8'(TICK_CYCLES - 1);
		next_tick_count = next_tick ? 8'h00 : tick_count + 8'h01;
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_count <= 8'h00;
			tick <= 1'b0;
		end else begin
			tick_count <= next_tick_count;
			tick <= next_tick;
		end
	end

	// ==========================================================
	// Configuration state
	logic [31:0] conn_mode, next_conn_mode;
	logic [31:0] restore_cmd, next_restore_cmd;
	logic [15:0] next_safety_addr;
	logic [31:0] next_crc_value;
	logic [7:0] next_pd_size;
	logic next_safety_enable;
	logic [CHANNELS-1:0] wb_disable, next_wb_disable;
	logic [15:0] out_data [CHANNELS];
	logic [15:0] next_out_data [CHANNELS];
	logic next_ack, next_abort;
	logic [31:0] next_rdata;

	always_comb begin
		int chi;
		logic do_restore;
		chi = int'(od_index[7:4]);
		do_restore = 1'b0;
		next_conn_mode = conn_mode;
		next_restore_cmd = restore_cmd;
		next_safety_addr = safety_addr;
		next_pd_size = pd_size;
		next_wb_disable = wb_disable;
		next_out_data = out_data;
		next_ack = od_req;
		next_abort = 1'b0;
		next_rdata = 32'h00000000;
		next_safety_enable = slot_configured;
		if (od_req) begin
			if (od_index == RESTORE_INDEX && od_subindex == SUB_COUNT) begin
				next_abort = od_write;
				next_rdata = {24'h000000, RESTORE_COUNT_VALUE};
			end else if (od_index == RESTORE_INDEX && od_subindex == SUB_RESTORE_CMD) begin
				next_rdata = restore_cmd;
				if (od_write) begin
					next_restore_cmd = od_wdata;
					// Only the exact key restores; other values are merely stored.
					do_restore = od_wdata == RESTORE_KEY;
				end
			end else if (od_index == SAFETY_INDEX && od_subindex == SUB_SAFETY_ADDR) begin
				next_rdata = {16'h0000, safety_addr};
				if (od_write) begin
					next_safety_addr = od_wdata[15:0];
				end
			end else if (od_index == SAFETY_INDEX && od_subindex == SUB_CONN_MODE) begin
				next_rdata = conn_mode;
				if (od_write && mode_ok(od_wdata)) begin
					next_conn_mode = od_wdata;
				end else if (od_write) begin
					next_abort = 1'b1;
				end
			end else if (od_index == SAFETY_INDEX && od_subindex == SUB_PD_SIZE) begin
				next_rdata = {24'h000000, pd_size};
				if (od_write && od_wdata <= {24'h000000, PD_SIZE_FULL}) begin
					next_pd_size = od_wdata[7:0];
				end else if (od_write) begin
					next_abort = 1'b1;
				end
			end else if (area_hit(od_index, CONFIG_AREA) && od_subindex == SUB_WB_DISABLE) begin
				next_rdata = {31'h00000000, wb_disable[chi]};
				if (od_write && WB_OFF_SUPPORTED) begin
					next_wb_disable[chi] = od_wdata[0];
				end else if (od_write) begin
					next_abort = 1'b1;
				end
			end else if (area_hit(od_index, INPUT_AREA) && od_subindex == SUB_VALUE) begin
				next_abort = od_write;
				next_rdata = {16'h0000, ch_value[chi*16 +: 16]};
			end else if (area_hit(od_index, OUTPUT_AREA) && od_subindex == SUB_VALUE) begin
				next_rdata = {16'h0000, out_data[chi]};
				if (od_write) begin
					next_out_data[chi] = od_wdata[15:0];
				end
			end else begin
				next_abort = 1'b1;
			end
		end
		if (next_safety_enable && !safety_enable) begin
			next_pd_size = PD_SIZE_FULL;
		end
		if (do_restore) begin
			next_conn_mode = CONN_MODE_RESET;
			next_safety_addr = SAFETY_ADDR_RESET;
			next_pd_size = PD_SIZE_FULL;
			next_wb_disable = '0;
			for (int i = 0; i < CHANNELS; i++) begin
				next_out_data[i] = OUT_DATA_RESET;
			end
		end
		next_crc_value = crc_of(next_conn_mode);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			conn_mode <= CONN_MODE_RESET;
			restore_cmd <= RESTORE_CMD_RESET;
			safety_addr <= SAFETY_ADDR_RESET;
			crc_value <= CRC_POLY_1;
			pd_size <= PD_SIZE_FULL;
			safety_enable <= 1'b0;
			wb_disable <= '0;
			for (int i = 0; i < CHANNELS; i++) begin
				out_data[i] <= OUT_DATA_RESET;
			end
			od_ack <= 1'b0;
			od_abort <= 1'b0;
			od_rdata <= 32'h00000000;
		end else begin
			conn_mode <= next_conn_mode;
			restore_cmd <= next_restore_cmd;
			safety_addr <= next_safety_addr;
			crc_value <= next_crc_value;
			pd_size <= next_pd_size;
			safety_enable <= next_safety_enable;
			wb_disable <= next_wb_disable;
			out_data <= next_out_data;
			od_ack <= next_ack;
			od_abort <= next_abort;
			od_rdata <= next_rdata;
		end
	end

	// ==========================================================
	// Channels
	for (genvar n = 0; n < CHANNELS; n++) begin : g_ch
		assign out_value[n*16 +: 16] = out_data[n];
		wire_test_timer #(
			.PERIOD_US(PERIOD_US),
			.PULSE_US(PULSE_US),
			.TICK_CYCLES(TICK_CYCLES)
		) u_test (
			.clk(clk),
			.reset_n(reset_n),
			.tick(tick),
			.test_enable(!wb_disable[n]),
			.test_current(test_current[n]),
			.sample_enable(sample_enable[n])
		);
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence restore_wr;
		od_req && od_write && od_index == RESTORE_INDEX && od_subindex == SUB_RESTORE_CMD;
	endsequence
	sequence mode_wr;
		od_req && od_write && od_index == SAFETY_INDEX && od_subindex == SUB_CONN_MODE;
	endsequence

	channel_off_a: assert property (!slot_configured |=> !safety_enable)
		else $error("safety channel enabled without slot");
	crc_first_a: assert property (conn_mode == CRC_SEL_FIRST |-> crc_value == CRC_POLY_1)
		else $error("selection one does not give first polynomial");
	crc_last_a: assert property (conn_mode == CRC_SEL_LAST |-> crc_value == CRC_POLY_8)
		else $error("selection eight does not give last polynomial");
	mode_store_a: assert property (mode_wr and mode_ok(od_wdata) |=>
		conn_mode == $past(od_wdata) && od_ack && !od_abort)
		else $error("valid connection mode not stored");
	free_reject_a: assert property (mode_wr and !mode_ok(od_wdata) |=> $stable(conn_mode) && od_abort)
		else $error("bad free checksum accepted");
	addr_write_a: assert property (od_req && od_write && od_index == SAFETY_INDEX && od_subindex == SUB_SAFETY_ADDR
		|=> safety_addr == $past(od_wdata[15:0]))
		else $error("safety address not stored");
	full_pd_a: assert property ($rose(safety_enable) |-> pd_size == PD_SIZE_FULL)
		else $error("full process data not offered on enable");
	restore_key_a: assert property (restore_wr and od_wdata == RESTORE_KEY |=>
		conn_mode == CONN_MODE_RESET && safety_addr == SAFETY_ADDR_RESET && wb_disable == '0)
		else $error("restore key did not restore defaults");
	wrong_key_a: assert property (restore_wr and od_wdata != RESTORE_KEY |=>
		$stable(conn_mode) && $stable(safety_addr) && $stable(wb_disable))
		else $error("wrong restore value changed configuration");
	sample_gap_a: assert property ((test_current & sample_enable) == '0)
		else $error("sampling during test pulse");
	input_area_a: assert property (od_req && !od_write && od_index == {INPUT_AREA, 12'h000} && od_subindex == SUB_VALUE
		|=> od_rdata[15:0] == $past(ch_value[15:0]))
		else $error("input area read wrong");
	restore_c: cover property (restore_wr and od_wdata == RESTORE_KEY);
	free_crc_c: cover property (mode_wr and od_wdata[31:16] == FREE_PREFIX);
	enable_c: cover property ($rose(safety_enable));
	pulse_c: cover property ($rose(test_current[0]));
endmodule : safety_channel_config_objects
`default_nettype wire

// [design/safety_cfg_pkg.sv]
// Shared constants for the safety channel configuration objects.
package safety_cfg_pkg;
	// ==========================================================
	// Object dictionary layout
	localparam logic [15:0] RESTORE_INDEX = 16'h1011;
	localparam logic [15:0] SAFETY_INDEX_DEFAULT = 16'h8040;
	localparam logic [3:0] INPUT_AREA = 4'h6;
	localparam logic [3:0] OUTPUT_AREA = 4'h7;
	localparam logic [3:0] CONFIG_AREA = 4'h8;
	localparam logic [3:0] AREA_PAD = 4'h0;
	localparam logic [7:0] SUB_COUNT = 8'h00;
	localparam logic [7:0] SUB_RESTORE_CMD = 8'h01;
	localparam logic [7:0] SUB_SAFETY_ADDR = 8'h01;
	localparam logic [7:0] SUB_CONN_MODE = 8'h02;
	localparam logic [7:0] SUB_PD_SIZE = 8'h03;
	localparam logic [7:0] SUB_WB_DISABLE = 8'h0e;
	localparam logic [7:0] SUB_VALUE = 8'h11;
	// ==========================================================
	// Values and reset values
	localparam logic [7:0] RESTORE_COUNT_VALUE = 8'h01;
	localparam logic [31:0] RESTORE_KEY = 32'h64616f6c;
	localparam logic [31:0] RESTORE_CMD_RESET = 32'h00000000;
	localparam logic [15:0] SAFETY_ADDR_RESET = 16'h0000;
	localparam logic [31:0] CONN_MODE_RESET = 32'h00000001;
	localparam logic [7:0] PD_SIZE_FULL = 8'h04;
	localparam logic [15:0] OUT_DATA_RESET = 16'h0000;
	localparam logic [15:0] FREE_PREFIX = 16'h00ff;
	localparam logic [31:0] CRC_SEL_FIRST = 32'h00000001;
	localparam logic [31:0] CRC_SEL_LAST = 32'h00000008;
	localparam logic [31:0] CRC_POLY_1 = 32'h00017b0f;
	localparam logic [31:0] CRC_POLY_2 = 32'h0001571f;
	localparam logic [31:0] CRC_POLY_3 = 32'h00011f95;
	localparam logic [31:0] CRC_POLY_4 = 32'h000153f1;
	localparam logic [31:0] CRC_POLY_5 = 32'h0001f1d5;
	localparam logic [31:0] CRC_POLY_6 = 32'h0001663b;
	localparam logic [31:0] CRC_POLY_7 = 32'h0001b8cd;
	localparam logic [31:0] CRC_POLY_8 = 32'h0001e1bd;
	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TEST_PERIOD_US = 1000;
	localparam int TEST_PULSE_US = 50;

	// Values with the free prefix pass through as free values; anything else maps by its low four bits to the table, 0 and 8 and above to the last.
	function automatic logic [31:0] crc_of(input logic [31:0] mode);
		if (mode[31:16] == FREE_PREFIX) begin
			return mode;
		end
		case (mode[3:0])
			4'h1: return CRC_POLY_1;
			4'h2: return CRC_POLY_2;
			4'h3: return CRC_POLY_3;
			4'h4: return CRC_POLY_4;
			4'h5: return CRC_POLY_5;
			4'h6: return CRC_POLY_6;
			4'h7: return CRC_POLY_7;
			default: return CRC_POLY_8;
		endcase
	endfunction : crc_of

	function automatic logic mode_ok(input logic [31:0] mode);
		return (mode >= CRC_SEL_FIRST && mode <= CRC_SEL_LAST) || mode[31:16] == FREE_PREFIX;
	endfunction : mode_ok
endpackage : safety_cfg_pkg

// [design/wire_test_timer.sv]
// Open-wire test pulse generator for one input channel.
`timescale 1ns/100ps
`default_nettype none
module wire_test_timer #(
	parameter int PERIOD_US = 1000,
	parameter int PULSE_US = 50,
	parameter int TICK_CYCLES = 25
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Control
	input wire logic tick,
	input wire logic test_enable,
	// Channel
	output logic test_current,
	output logic sample_enable
);
	typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_PULSE = 2'b10} test_state_t;
	test_state_t state, next_state;
	logic [15:0] count, next_count;
	logic next_current;

	if (PERIOD_US < 2 || PERIOD_US > 65535 || PULSE_US < 1 || PULSE_US >= PERIOD_US) begin : g_check
		$error("wire_test_timer: period or pulse length out of range");
	end

	always_comb begin
		next_state = state;
		next_count = count;
		case (state)
			ST_IDLE: begin
				if (!test_enable) begin
					next_count = 16'h0000;
				end else if (tick) begin
					if (count == 16'(PERIOD_US - 1)) begin
						next_state = ST_PULSE;
						next_count = 16'h0000;
					end else begin
						next_count = count + 16'h0001;
					end
				end
			end
			ST_PULSE: begin
				if (tick) begin
					if (count == 16'(PULSE_US - 1)) begin
						next_state = ST_IDLE;
						next_count = 16'h0000;
					end else begin
						next_count = count + 16'h0001;
					end
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_count = 16'h0000;
			end
		endcase
		next_current = next_state == ST_PULSE;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_IDLE;
			count <= 16'h0000;
			test_current <= 1'b0;
			sample_enable <= 1'b1;
		end else begin
			state <= next_state;
			count <= next_count;
			test_current <= next_current;
			// Sampling and the test current share one edge, so they never overlap.
			sample_enable <= !next_current;
		end
	end

	// ==========================================================
	// Checks
	localparam int IDLE_LIMIT = (PERIOD_US + 1) * TICK_CYCLES;
	int idle_len;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			idle_len <= 0;
		end else begin
			idle_len <= (state == ST_IDLE && test_enable) ? idle_len + 1 : 0;
		end
	end
	test_period_a: assert property (@(posedge clk) disable iff (!reset_n) idle_len <= IDLE_LIMIT)
		else $error("open-wire test pulse overdue");
	test_off_a: assert property (@(posedge clk) disable iff (!reset_n)
		(state == ST_IDLE && !test_enable) |=> !test_current)
		else $error("test pulse started while testing disabled");
	pulse_seen_c: cover property (@(posedge clk) disable iff (!reset_n) $fell(test_current));
endmodule : wire_test_timer
`default_nettype wire

// [tb/fieldbus_master_model.sv]
// Behavioural fieldbus master that configures the safety link through object accesses.
`timescale 1ns/100ps
`default_nettype none
module fieldbus_master_model
	import safety_cfg_pkg::*;
(
	// Clock
	input wire logic clk,
	// Object dictionary access
	output logic od_req,
	output logic od_write,
	output logic [15:0] od_index,
	output logic [7:0] od_subindex,
	output logic [31:0] od_wdata,
	input wire logic od_ack,
	input wire logic od_abort,
	input wire logic [31:0] od_rdata
);
	logic [31:0] used_crc [$];

	initial begin
		od_req = 1'b0;
		od_write = 1'b0;
		od_index = 16'h0000;
		od_subindex = 8'h00;
		od_wdata = 32'h00000000;
	end

	// ==========================================================
	// One access: request held until the taking edge, answer read just after it.
	task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
		output logic [31:0] rd, output logic ab);
		@(posedge clk);
		od_req <= 1'b1;
		od_write <= wr;
		od_index <= idx;
		od_subindex <= sub;
		od_wdata <= wd;
		@(posedge clk);
		od_req <= 1'b0;
		// Released lines flip so that a stale value is never taken for a held one.
		od_index <= ~idx;
		od_subindex <= ~sub;
		od_wdata <= ~wd;
		#1;
		rd = od_ack ? od_rdata : 32'hxxxxxxxx;
		ab = od_ack ? od_abort : 1'bx;
	endtask : access

	// ==========================================================
	// A free checksum carries the fixed prefix and differs from every one already handed out.
	function automatic logic [31:0] free_mode(input logic [15:0] low);
		logic [31:0] m;
		m = {FREE_PREFIX, low};
		while (m inside {used_crc}) begin
			m[15:0] = m[15:0] + 16'h0001;
		end
		used_crc.push_back(m);
		return m;
	endfunction : free_mode
endmodule : fieldbus_master_model
`default_nettype wire

// [tb/tb.sv]
// Self-checking testbench for the safety channel configuration objects.
`timescale 1ns/100ps
`default_nettype none
module tb;
	import safety_cfg_pkg::*;
	localparam int CH = 4;
	localparam int TCK = 25;
	localparam int PULSE = 2;
	localparam logic [15:0] SIDX = 16'h8040;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic slot_configured = 1'b0;
	logic [CH*16-1:0] ch_value = '0;
	logic od_req, od_write, od_ack, od_abort, safety_enable;
	logic [15:0] od_index, safety_addr;
	logic [7:0] od_subindex, pd_size;
	logic [31:0] od_wdata, od_rdata, crc_value, rd, v;
	logic [CH*16-1:0] out_value;
	logic [CH-1:0] test_current, sample_enable;
	logic ab;
	integer seed = 91109;
	int miscompares = 0;
	int checked = 0;
	int hi, cnt, bad;
	logic [31:0] bad_modes [3] = '{32'h0, 32'h9, 32'h00fe0000};

	always #20 clk = ~clk;

	safety_channel_config_objects #(.CHANNELS(CH), .SAFETY_INDEX(SIDX), .WB_OFF_SUPPORTED(1'b1),
		.PERIOD_US(4), .PULSE_US(PULSE)) u_safety_channel_config_objects (.clk(clk), .reset_n(reset_n),
		.od_req(od_req), .od_write(od_write), .od_index(od_index), .od_subindex(od_subindex),
		.od_wdata(od_wdata), .od_ack(od_ack), .od_abort(od_abort), .od_rdata(od_rdata),
		.slot_configured(slot_configured), .safety_enable(safety_enable), .safety_addr(safety_addr),
		.crc_value(crc_value), .pd_size(pd_size), .ch_value(ch_value), .out_value(out_value),
		.test_current(test_current), .sample_enable(sample_enable));

	fieldbus_master_model u_fieldbus_master_model (.clk(clk), .od_req(od_req), .od_write(od_write),
		.od_index(od_index), .od_subindex(od_subindex), .od_wdata(od_wdata), .od_ack(od_ack),
		.od_abort(od_abort), .od_rdata(od_rdata));

	// ==========================================================
	// Helpers
	function automatic logic [31:0] exp_crc(input logic [31:0] m);
		case (m)
			32'h1: return 32'h00017b0f;
			32'h2: return 32'h0001571f;
			32'h3: return 32'h00011f95;
			32'h4: return 32'h000153f1;
			32'h5: return 32'h0001f1d5;
			32'h6: return 32'h0001663b;
			32'h7: return 32'h0001b8cd;
			32'h8: return 32'h0001e1bd;
			default: return m;
		endcase
	endfunction : exp_crc

	task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd);
		u_fieldbus_master_model.access(wr, idx, sub, wd, rd, ab);
	endtask : acc

	// Waits for a pulse on channel c and measures it; sampling must stay off throughout.
	task automatic pulse_len(input int c);
		hi = 0;
		bad = 0;
		cnt = 0;
		// A pulse already running when we arrive would be measured short, so let it end first.
		while (test_current[c] === 1'b1 && cnt < 400) begin
			@(posedge clk);
			#1;
			cnt++;
		end
		while (test_current[c] !== 1'b1 && cnt < 400) begin
			@(posedge clk);
			#1;
			cnt++;
		end
		while (test_current[c] === 1'b1 && hi < 400) begin
			if (sample_enable[c] !== 1'b0) bad++;
			@(posedge clk);
			#1;
			hi++;
		end
	endtask : pulse_len

	task automatic summarize;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : summarize

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		summarize();
	end

	// ==========================================================
	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		#1;
		check({safety_enable, safety_addr, crc_value, pd_size}, {1'b0, 16'h0, 32'h17b0f, 8'h04}, "reset");
		check(sample_enable, {CH{1'b1}}, "sampling at reset");
		acc(0, RESTORE_INDEX, SUB_COUNT, 0);
		check({ab, rd}, {1'b0, 32'h1}, "restore count");
		acc(1, RESTORE_INDEX, SUB_COUNT, 5);
		check(ab, 1'b1, "count is read-only");
		acc(0, RESTORE_INDEX, SUB_RESTORE_CMD, 0);
		check({ab, rd}, {1'b0, 32'h0}, "restore cmd reset");
		check(safety_enable, 1'b0, "off without slot");
		@(posedge clk);
		slot_configured <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check({safety_enable, pd_size}, {1'b1, 8'h04}, "enabled full data");
		acc(1, SIDX, SUB_PD_SIZE, 2);
		check({ab, pd_size}, {1'b0, 8'h02}, "narrowed data");
		acc(1, SIDX, SUB_PD_SIZE, 5);
		check({ab, pd_size}, {1'b1, 8'h02}, "oversize refused");
		@(posedge clk);
		slot_configured <= 1'b0;
		repeat (2) @(posedge clk);
		slot_configured <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check({safety_enable, pd_size}, {1'b1, 8'h04}, "re-enable full data");
		for (int i = 1; i <= 8; i++) begin
			acc(1, SIDX, SUB_CONN_MODE, i);
			check({ab, crc_value}, {1'b0, exp_crc(i)}, "fixed checksum");
			acc(0, SIDX, SUB_CONN_MODE, 0);
			check(rd, i, "mode readback");
		end
		foreach (bad_modes[k]) begin
			acc(1, SIDX, SUB_CONN_MODE, bad_modes[k] | ($random(seed) & 32'h0000fff0 & {32{k == 2}}));
			check({ab, crc_value}, {1'b1, exp_crc(8)}, "bad mode kept");
		end
		for (int i = 0; i < 2; i++) begin
			v = u_fieldbus_master_model.free_mode(16'($random(seed)));
			acc(1, SIDX, SUB_CONN_MODE, v);
			check({ab, crc_value}, {1'b0, v}, "free checksum");
		end
		v = $random(seed);
		acc(1, SIDX, SUB_SAFETY_ADDR, v);
		check({ab, safety_addr}, {1'b0, v[15:0]}, "safety address");
		acc(0, SIDX, SUB_SAFETY_ADDR, 0);
		check(rd, {16'h0, v[15:0]}, "address readback");
		acc(1, 16'h8010, SUB_SAFETY_ADDR, 7);
		check({ab, safety_addr}, {1'b1, v[15:0]}, "foreign index");
		for (int n = 0; n <= CH; n++) begin
			@(posedge clk);
			ch_value <= {$random(seed), $random(seed)};
			v = $random(seed);
			acc(1, {OUTPUT_AREA, 4'h0, n[3:0], 4'h0}, SUB_VALUE, v);
			check(ab, n == CH, "output write");
			if (n < CH) check(out_value[n*16+:16], v[15:0], "output area");
			acc(0, {INPUT_AREA, 4'h0, n[3:0], 4'h0}, SUB_VALUE, 0);
			if (n < CH) check({ab, rd}, {1'b0, 16'h0, ch_value[n*16+:16]}, "input area");
			acc(1, {INPUT_AREA, 4'h0, n[3:0], 4'h0}, SUB_VALUE, v);
			check(ab, 1'b1, "input read-only");
		end
		v = {16'h0, safety_addr};
		acc(1, RESTORE_INDEX, SUB_RESTORE_CMD, 32'h64616f6d);
		check({safety_addr, crc_value}, {v[15:0], u_fieldbus_master_model.used_crc[1]}, "wrong key");
		acc(1, {CONFIG_AREA, 12'h000}, SUB_WB_DISABLE, 1);
		pulse_len(1);
		check({hi, bad}, {PULSE * TCK, 32'd0}, "pulse width");
		cnt = 0;
		repeat (400) begin
			@(posedge clk);
			#1;
			cnt += test_current[0];
		end
		check(cnt, 0, "wire test off");
		acc(1, RESTORE_INDEX, SUB_RESTORE_CMD, RESTORE_KEY);
		check({safety_addr, crc_value, pd_size}, {16'h0, 32'h17b0f, 8'h04}, "restore");
		check(out_value, {CH*16{1'b0}}, "restore outputs");
		acc(0, RESTORE_INDEX, SUB_RESTORE_CMD, 0);
		check(rd, RESTORE_KEY, "key kept");
		pulse_len(0);
		check({hi, bad}, {PULSE * TCK, 32'd0}, "wire test back");
		summarize();
	end
endmodule : tb
`default_nettype wire
